// *** kdi_asserts.sv ***
// port checker for kdi_core, bound into each instance
// assumes the single system clock domain and async high reset
`timescale 1ns/100ps
module kdi_asserts #(
  parameter int unsigned TICK_CYCLES = 4 // cycles per awake tick
) (
  input wire logic                         clk_sys_in,       // clock
  input wire logic                         rst_in,           // reset
  input wire logic [7:0]                   setup_addr_in,    // address
  input wire logic                         setup_wr_in,      // write
  input wire logic [7:0]                   setup_wdata_in,   // wdata
  input wire logic [7:0]                   setup_rdata_out,  // rdata
  input wire logic                         acq_req_out,      // request
  input wire logic [kdi_pkg::KEY_W-1:0]    acq_key_out,      // key
  input wire logic                         fast_burst_out,   // burst
  input wire logic                         acq_valid_in,     // result
  input wire logic                         calibrating_in,   // calibrating
  input wire logic                         sleep_en_in,      // sleep on
  input wire logic                         change_ack_in,    // ack
  input wire logic [kdi_pkg::NUM_KEYS-1:0] key_detect_out,   // detect
  input wire logic                         awake_out,        // awake
  input wire logic                         change_pin_o_out, // pin value
  input wire logic                         change_pin_oe_out // pin drive
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic in_map;
  assign in_map = (setup_addr_in >= kdi_pkg::SETUP_BASE) && (setup_addr_in <= kdi_pkg::SETUP_LAST);

  a_req_pulse: assert property (acq_req_out |=> !acq_req_out)
    else $error("request wider than one cycle");
  a_req_after_valid: assert property (acq_valid_in |=> !acq_req_out ##[1:30] acq_req_out)
    else $error("no next request after result");
  a_burst_key: assert property (acq_valid_in && fast_burst_out |=> !fast_burst_out || $stable(acq_key_out))
    else $error("burst left its key");
  a_unmapped_zero: assert property (!in_map |=> setup_rdata_out == kdi_pkg::UNMAPPED_RD)
    else $error("unmapped read not zero");
  a_write_back: assert property ((setup_wr_in && in_map) ##1 ($stable(setup_addr_in) && !setup_wr_in)
    |=> setup_rdata_out == $past(setup_wdata_in, 2))
    else $error("setup readback wrong");
  a_detect_cause: assert property ($changed(key_detect_out) |-> $past(acq_valid_in) || $past(setup_wr_in, 2))
    else $error("detect moved without cause");
  a_change_cause: assert property ($rose(change_pin_oe_out) |-> $changed(key_detect_out))
    else $error("change without detect edge");
  a_ack_clears: assert property (change_ack_in && !acq_valid_in |=> !change_pin_oe_out)
    else $error("change not cleared by ack");
  a_pin_low: assert property (change_pin_o_out == 1'b0)
    else $error("change pin drives high");
  a_never_sleep: assert property (!sleep_en_in |=> awake_out)
    else $error("asleep with sleep off");
  a_busy_awake: assert property ((|key_detect_out || calibrating_in) && awake_out |=> awake_out)
    else $error("slept while busy");

  c_burst: cover property (fast_burst_out && acq_valid_in);
  c_detect: cover property ($rose(|key_detect_out));
  c_sleep: cover property ($fell(awake_out));
endmodule

bind kdi_core kdi_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .setup_addr_in(setup_addr_in), .setup_wr_in(setup_wr_in),
  .setup_wdata_in(setup_wdata_in), .setup_rdata_out(setup_rdata_out), .acq_req_out(acq_req_out),
  .acq_key_out(acq_key_out), .fast_burst_out(fast_burst_out), .acq_valid_in(acq_valid_in),
  .calibrating_in(calibrating_in), .sleep_en_in(sleep_en_in), .change_ack_in(change_ack_in),
  .key_detect_out(key_detect_out), .awake_out(awake_out), .change_pin_o_out(change_pin_o_out),
  .change_pin_oe_out(change_pin_oe_out));

// *** kdi_core.sv ***
// key detect integrator: scan sequencer, fast and normal integrators,
// relative suppression and wake-on-touch change signalling
// assumes the acquisition front end answers each request with one valid pulse
//
// Overview of operation
// - normal limit index zero disables a key; nonzero enables it.
// - each key keeps its own count, up on crossing, down otherwise.
// - first crossing below negative threshold enters fast burst on that key.
// - each key has its own fast limit, one to fifteen.
// - fast burst stays on key until limit or zero, then moves on.
// - normal count tallies fast limits reached, at most once per scan.
// - key active when normal count reaches normal limit.
// - fast limit one means single acquisition per rotation.
// - fast count steps up at or below threshold, down above it.
// - disabled keys are skipped in the scan.
// - normal limit is table index; 1 gives 2, 2 gives 4; default 2.
// - fast limit is table index; 2 gives 4, 3 gives 6; default 3.
// - suppress enabled key while another enabled key deviates more negatively.
// - a detected key holds detect while touched, ignoring suppression.
// - suppression compares raw deviations only.
// - suppression enable defaults off.
// - wake-enabled key drives change output on touch and release, and wakes.
// - independent per-key wake enable, default on.
// - once awake, any key activity extends awake time.
// - stay awake a set time after last release.
// - touch recognised when filtered signal crosses negative threshold downward.
// - never sleep while any key detects or calibrates.
`timescale 1ns/100ps
module kdi_core #(
  parameter int unsigned TICK_CYCLES = kdi_pkg::AWAKE_TICK_CYCLES // cycles per awake tick
) (
  input  wire logic                               clk_sys_in,      // system clock
  input  wire logic                               rst_in,          // async reset, high
  input  wire logic [7:0]                         setup_addr_in,   // setup byte address
  input  wire logic                               setup_wr_in,     // setup write strobe
  input  wire logic [7:0]                         setup_wdata_in,  // setup write data
  output logic      [7:0]                         setup_rdata_out, // setup read data
  output logic                                    acq_req_out,     // acquire request pulse
  output logic      [kdi_pkg::KEY_W-1:0]          acq_key_out,     // key to acquire
  output logic                                    fast_burst_out,  // in fast burst mode
  input  wire logic                               acq_valid_in,    // acquisition done pulse
  input  wire logic                               acq_touch_in,    // signal at or below threshold
  input  wire logic signed [kdi_pkg::DELTA_W-1:0] acq_delta_in,    // reference minus signal
  input  wire logic                               calibrating_in,  // some key calibrating
  input  wire logic                               sleep_en_in,     // sleep feature on
  input  wire logic [kdi_pkg::AWAKE_W-1:0]        awake_time_in,   // awake ticks after release
  input  wire logic                               change_ack_in,   // host clears change
  output logic      [kdi_pkg::NUM_KEYS-1:0]       key_detect_out,  // per-key detect state
  output logic                                    awake_out,       // device awake
  input  wire logic                               change_pin_in,   // change pin level, unused
  output logic                                    change_pin_o_out,  // change pin drive value
  output logic                                    change_pin_oe_out  // change pin pulled low
);

  localparam int unsigned NK = kdi_pkg::NUM_KEYS;
  localparam int unsigned KW = kdi_pkg::KEY_W;
  localparam int unsigned FW = kdi_pkg::FAST_W;
  localparam int unsigned NW = kdi_pkg::NORM_W;
  localparam int unsigned DW = kdi_pkg::DELTA_W;

  logic [NK-1:0]   wake_en;
  logic [NK-1:0]   supp_en;
  logic [NK*4-1:0] fast_idx;
  logic [NK*2-1:0] norm_idx;
  logic [NK-1:0]   key_en;
  logic [NK-1:0]   beaten;

  kdi_setup_bank u_bank (
    .clk_sys_in     (clk_sys_in),
    .rst_in         (rst_in),
    .setup_addr_in  (setup_addr_in),
    .setup_wr_in    (setup_wr_in),
    .setup_wdata_in (setup_wdata_in),
    .setup_rdata_out(setup_rdata_out),
    .wake_en_out    (wake_en),
    .supp_en_out    (supp_en),
    .fast_idx_out   (fast_idx),
    .norm_idx_out   (norm_idx)
  );

  // per-key state
  logic [FW-1:0]        fast_ff   [NK];
  logic [FW-1:0]        nxt_fast  [NK];
  logic [NW-1:0]        norm_ff   [NK];
  logic [NW-1:0]        nxt_norm  [NK];
  logic signed [DW-1:0] delta_ff  [NK];
  logic signed [DW-1:0] nxt_delta [NK];
  logic [NK-1:0]        detect_ff;
  logic [NK-1:0]        nxt_detect;
  logic [NK-1:0]        adv_ff;
  logic [NK-1:0]        nxt_adv;

  // sequencer
  kdi_pkg::kdi_seq_type seq_ff;
  kdi_pkg::kdi_seq_type nxt_seq;
  logic [KW-1:0]        cur_ff;
  logic [KW-1:0]        nxt_cur;
  logic                 req_ff;
  logic                 nxt_req;
  logic                 burst_ff;
  logic                 nxt_burst;
  logic [KW-1:0]        next_key;
  logic                 next_wraps;

  // awake and change
  logic                 change_ff;
  logic                 nxt_change;
  logic                 awake_ff;
  logic                 nxt_awake;
  logic [kdi_pkg::AWAKE_W-1:0] awake_cnt_ff;
  logic [kdi_pkg::AWAKE_W-1:0] nxt_awake_cnt;
  logic [31:0]          tick_ff;
  logic [31:0]          nxt_tick;

  for (genvar k = 0; k < NK; k++) begin : g_key
    assign key_en[k] = norm_idx[k*2 +: 2] != 2'h0_0;
    // raw deviation only, no gain or threshold scaling
    assign beaten[k] = supp_en[k] && (k != int'(cur_ff)) && (delta_ff[k] > acq_delta_in);
  end

  // next enabled key after the current one, circularly
  always_comb begin
    int idx;
    idx        = 0;
    next_key   = cur_ff;
    next_wraps = 1'b0;
    for (int i = NK; i >= 1; i--) begin
      idx = int'(cur_ff) + i;
      if (idx >= NK) begin
        idx = idx - NK;
      end
      if (key_en[idx]) begin
        next_key   = KW'(idx);
        next_wraps = (int'(cur_ff) + i) >= NK;
      end
    end
  end

  always_comb begin
    logic [FW-1:0] flim;
    logic [NW-1:0] nlim;
    logic [FW-1:0] fnew;
    logic          touch_eff;
    logic          locked;
    flim       = kdi_pkg::FAST_LUT[fast_idx[cur_ff*4 +: 4]];
    nlim       = kdi_pkg::NORM_LUT[norm_idx[cur_ff*2 +: 2]];
    fnew       = '0;
    touch_eff  = 1'b0;
    locked     = 1'b0;
    nxt_fast   = fast_ff;
    nxt_norm   = norm_ff;
    nxt_delta  = delta_ff;
    nxt_detect = detect_ff;
    nxt_adv    = adv_ff;
    nxt_seq    = seq_ff;
    nxt_cur    = cur_ff;
    nxt_req    = 1'b0;
    nxt_burst  = burst_ff;
    case (seq_ff)
      kdi_pkg::SEQ_REQ: begin
        if (key_en[cur_ff]) begin
          nxt_req = 1'b1;
          nxt_seq = kdi_pkg::SEQ_WAIT;
        end else begin
          nxt_cur = next_key;
        end
      end
      kdi_pkg::SEQ_WAIT: begin
        if (acq_valid_in) begin
          nxt_seq = kdi_pkg::SEQ_REQ;
          if (supp_en[cur_ff]) begin
            nxt_delta[cur_ff] = acq_delta_in;
          end
          if (detect_ff[cur_ff]) begin
            if (!acq_touch_in) begin
              nxt_detect[cur_ff] = 1'b0; // release
              nxt_fast[cur_ff]   = '0;
              nxt_norm[cur_ff]   = '0;
            end
            // held regardless of other keys' deviations
          end else begin
            touch_eff = acq_touch_in && !(supp_en[cur_ff] && |beaten);
            if (touch_eff) begin
              fnew = fast_ff[cur_ff] + FW'(1);
            end else if (fast_ff[cur_ff] != '0) begin
              fnew = fast_ff[cur_ff] - FW'(1);
            end
            if (touch_eff && fnew >= flim) begin
              nxt_fast[cur_ff] = '0;
              if (!adv_ff[cur_ff]) begin
                nxt_adv[cur_ff] = 1'b1;
                if (norm_ff[cur_ff] + NW'(1) >= nlim) begin
                  nxt_detect[cur_ff] = 1'b1;
                  nxt_norm[cur_ff]   = '0;
                end else begin
                  nxt_norm[cur_ff] = norm_ff[cur_ff] + NW'(1);
                end
              end
            end else if (fnew == '0) begin
              nxt_fast[cur_ff] = '0;
              if (!touch_eff && norm_ff[cur_ff] != '0) begin
                nxt_norm[cur_ff] = norm_ff[cur_ff] - NW'(1);
              end
            end else begin
              nxt_fast[cur_ff] = fnew;
              locked           = 1'b1;
            end
          end
          nxt_burst = locked;
          if (!locked) begin
            nxt_cur = next_key;
            if (next_wraps) begin
              nxt_adv = '0; // one normal step per full scan
            end
          end
        end
      end
      default: begin
        nxt_seq = kdi_pkg::SEQ_REQ;
      end
    endcase
    for (int k = 0; k < NK; k++) begin
      if (!key_en[k]) begin
        nxt_fast[k]   = '0;
        nxt_norm[k]   = '0;
        nxt_detect[k] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      for (int k = 0; k < NK; k++) begin
        fast_ff[k]  <= '0;
        norm_ff[k]  <= '0;
        delta_ff[k] <= '0;
      end
      detect_ff <= '0;
      adv_ff    <= '0;
      seq_ff    <= kdi_pkg::SEQ_REQ;
      cur_ff    <= '0;
      req_ff    <= 1'b0;
      burst_ff  <= 1'b0;
    end else begin
      fast_ff   <= nxt_fast;
      norm_ff   <= nxt_norm;
      delta_ff  <= nxt_delta;
      detect_ff <= nxt_detect;
      adv_ff    <= nxt_adv;
      seq_ff    <= nxt_seq;
      cur_ff    <= nxt_cur;
      req_ff    <= nxt_req;
      burst_ff  <= nxt_burst;
    end
  end

  // change line and awake timer
  always_comb begin
    logic [NK-1:0] flips;
    flips         = detect_ff ^ nxt_detect;
    nxt_change    = change_ff;
    nxt_awake     = awake_ff;
    nxt_awake_cnt = awake_cnt_ff;
    nxt_tick      = tick_ff;
    if (change_ack_in) begin
      nxt_change = 1'b0;
    end
    if (|(flips & wake_en)) begin
      nxt_change = 1'b1; // set wins over ack
      nxt_awake  = 1'b1;
    end
    if (!sleep_en_in) begin
      nxt_awake = 1'b1;
    end
    if (|flips && (awake_ff || |(flips & wake_en))) begin
      nxt_awake_cnt = awake_time_in;
      nxt_tick      = '0;
    end else if (|detect_ff || calibrating_in || !awake_ff) begin
      nxt_awake_cnt = awake_time_in;
      nxt_tick      = '0;
    end else if (tick_ff >= 32'(TICK_CYCLES - 1)) begin
      nxt_tick = '0;
      if (awake_cnt_ff != '0) begin
        nxt_awake_cnt = awake_cnt_ff - 16'h0_001;
      end
    end else begin
      nxt_tick = tick_ff + 32'h0000_0001;
    end
    if (awake_ff && sleep_en_in && awake_cnt_ff == '0 && !(|detect_ff) && !calibrating_in
        && !(|flips)) begin
      nxt_awake = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      change_ff    <= 1'b0;
      awake_ff     <= 1'b1;
      awake_cnt_ff <= '0;
      tick_ff      <= '0;
    end else begin
      change_ff    <= nxt_change;
      awake_ff     <= nxt_awake;
      awake_cnt_ff <= nxt_awake_cnt;
      tick_ff      <= nxt_tick;
    end
  end

  assign acq_req_out       = req_ff;
  assign acq_key_out       = cur_ff;
  assign fast_burst_out    = burst_ff;
  assign key_detect_out    = detect_ff;
  assign awake_out         = awake_ff;
  assign change_pin_o_out  = 1'b0; // open drain: only ever pulls low
  assign change_pin_oe_out = change_ff;

endmodule

// *** kdi_frontend_model.sv ***
// acquisition front end model: one result pulse per request
// assumes one request outstanding; touch and depth per key set by the bench
`timescale 1ns/100ps
module kdi_frontend_model (
  input  wire logic                          clk_sys_in,   // clock
  input  wire logic                          rst_in,       // reset
  input  wire logic                          acq_req_in,   // request
  input  wire logic [kdi_pkg::KEY_W-1:0]     acq_key_in,   // key
  input  wire logic [kdi_pkg::NUM_KEYS-1:0]  touch_in,     // keys touched
  input  wire logic [kdi_pkg::NUM_KEYS-1:0]  deep_in,      // deeper deviation
  input  wire logic                          slow_in,      // random delay
  output logic                               acq_valid_out, // result pulse
  output logic                               acq_touch_out, // below threshold
  output logic signed [kdi_pkg::DELTA_W-1:0] acq_delta_out  // deviation
);
  int         seed = 96027;
  logic       busy;
  logic [2:0] wait_cnt;
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      busy <= 1'b0;
      wait_cnt <= 3'h0;
      acq_valid_out <= 1'b0;
      acq_touch_out <= 1'b0;
      acq_delta_out <= 16'h0000;
    end else begin
      acq_valid_out <= 1'b0;
      // no result pending: lines wander so stale values are never trusted
      acq_touch_out <= ~acq_touch_out;
      acq_delta_out <= 16'($random(seed));
      if (acq_req_in) begin
        busy <= 1'b1;
        wait_cnt <= slow_in ? 3'({$random(seed)} % 5) : 3'h0;
      end else if (busy && wait_cnt == 3'h0) begin
        busy <= 1'b0;
        acq_valid_out <= 1'b1;
        acq_touch_out <= touch_in[acq_key_in];
        acq_delta_out <= !touch_in[acq_key_in] ? 16'h0004 : deep_in[acq_key_in] ? 16'h0300 : 16'h0100;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 3'h1;
      end
    end
  end
endmodule

// *** kdi_pkg.sv ***
// key detect integrator package: setup layout, lookup tables, timing counts
// assumes a 24-key matrix with one setup byte per key
package kdi_pkg;

  localparam int unsigned NUM_KEYS  = 24;
  localparam int unsigned KEY_W     = 5;
  localparam int unsigned DELTA_W   = 16;
  localparam int unsigned FAST_W    = 5;
  localparam int unsigned NORM_W    = 4;
  localparam int unsigned AWAKE_W   = 16;

  // setup bank placement
  localparam logic [7:0] SETUP_BASE = 8'h00_A5;
  localparam logic [7:0] SETUP_LAST = 8'h00_BC;
  localparam logic [7:0] SETUP_RST  = 8'h00_8E;
  localparam logic [7:0] UNMAPPED_RD = 8'h00_00;

  // setup byte fields
  localparam int unsigned WAKE_BIT  = 7;
  localparam int unsigned SUPP_BIT  = 6;
  localparam int unsigned FAST_MSB  = 5;
  localparam int unsigned FAST_LSB  = 2;
  localparam int unsigned NORM_MSB  = 1;
  localparam int unsigned NORM_LSB  = 0;

  // index to confirmations
  localparam logic [NORM_W-1:0] NORM_LUT [4] = '{4'h0_0, 4'h0_2, 4'h0_4, 4'h0_8};
  localparam logic [FAST_W-1:0] FAST_LUT [16] = '{
    5'h00_00, 5'h00_01, 5'h00_04, 5'h00_06, 5'h00_08, 5'h00_0A, 5'h00_0C, 5'h00_0E,
    5'h00_10, 5'h00_12, 5'h00_14, 5'h00_16, 5'h00_18, 5'h00_1A, 5'h00_1C, 5'h00_1E};

  // awake time unit and clock
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned AWAKE_TICK_NS = 1_000_000;
  localparam int unsigned AWAKE_TICK_CYCLES = AWAKE_TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SEQ_REQ  = 2'b01,
    SEQ_WAIT = 2'b10
  } kdi_seq_type;

endpackage

// *** kdi_setup_bank.sv ***
// per-key setup byte bank behind a byte-wide port
// assumes one synchronous access per cycle; writes take effect at once
`timescale 1ns/100ps
module kdi_setup_bank (
  input  wire logic                              clk_sys_in,    // system clock
  input  wire logic                              rst_in,        // async reset, high
  input  wire logic [7:0]                        setup_addr_in, // byte address
  input  wire logic                              setup_wr_in,   // write strobe
  input  wire logic [7:0]                        setup_wdata_in,// write data
  output logic      [7:0]                        setup_rdata_out,// read data, registered
  output logic      [kdi_pkg::NUM_KEYS-1:0]      wake_en_out,   // per-key wake enable
  output logic      [kdi_pkg::NUM_KEYS-1:0]      supp_en_out,   // per-key suppression enable
  output logic      [kdi_pkg::NUM_KEYS*4-1:0]    fast_idx_out,  // per-key fast limit index
  output logic      [kdi_pkg::NUM_KEYS*2-1:0]    norm_idx_out   // per-key normal limit index
);

  logic [7:0] setup_ff [kdi_pkg::NUM_KEYS];
  logic [7:0] nxt_setup [kdi_pkg::NUM_KEYS];
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] offs;

  localparam int unsigned KEYW = kdi_pkg::KEY_W;

  assign offs = setup_addr_in - kdi_pkg::SETUP_BASE;

  always_comb begin
    nxt_setup = setup_ff;
    if (setup_addr_in >= kdi_pkg::SETUP_BASE && setup_addr_in <= kdi_pkg::SETUP_LAST) begin
      nxt_rdata = setup_ff[offs[KEYW-1:0]];
      if (setup_wr_in) begin
        nxt_setup[offs[KEYW-1:0]] = setup_wdata_in;
      end
    end else begin
      nxt_rdata = kdi_pkg::UNMAPPED_RD;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < kdi_pkg::NUM_KEYS; i++) begin
        setup_ff[i] <= kdi_pkg::SETUP_RST;
      end
      rdata_ff <= 8'h00_00;
    end else begin
      setup_ff <= nxt_setup;
      rdata_ff <= nxt_rdata;
    end
  end

  assign setup_rdata_out = rdata_ff;

  for (genvar k = 0; k < kdi_pkg::NUM_KEYS; k++) begin : g_key
    assign wake_en_out[k]        = setup_ff[k][kdi_pkg::WAKE_BIT];
    assign supp_en_out[k]        = setup_ff[k][kdi_pkg::SUPP_BIT];
    assign fast_idx_out[k*4 +: 4] = setup_ff[k][kdi_pkg::FAST_MSB:kdi_pkg::FAST_LSB];
    assign norm_idx_out[k*2 +: 2] = setup_ff[k][kdi_pkg::NORM_MSB:kdi_pkg::NORM_LSB];
  end

endmodule

// *** tb_top.sv ***
// self-checking bench for kdi_core with the front end model
// assumes 10 MHz clock and a four-cycle awake tick
`timescale 1ns/100ps
module tb_top;
  logic                          clk_sys_in = 1'b0;
  logic                          rst_in = 1'b1;
  logic [7:0]                    setup_addr_in = 8'h00;
  logic                          setup_wr_in = 1'b0;
  logic [7:0]                    setup_wdata_in = 8'h00;
  logic [7:0]                    setup_rdata_out;
  logic                          acq_req_out;
  logic [kdi_pkg::KEY_W-1:0]     acq_key_out;
  logic                          fast_burst_out;
  logic                          acq_valid_in;
  logic                          acq_touch_in;
  logic signed [15:0]            acq_delta_in;
  logic                          calibrating_in = 1'b0;
  logic                          sleep_en_in = 1'b0;
  logic [15:0]                   awake_time_in = 16'h0002;
  logic                          change_ack_in = 1'b0;
  logic [kdi_pkg::NUM_KEYS-1:0]  key_detect_out;
  logic                          awake_out;
  logic                          change_pin_o_out;
  logic                          change_pin_oe_out;
  logic [kdi_pkg::NUM_KEYS-1:0]  touch = 24'h00_0000;
  logic [kdi_pkg::NUM_KEYS-1:0]  deep = 24'h00_0000;
  logic [kdi_pkg::NUM_KEYS-1:0]  en_mask = 24'hFF_FFFF;
  logic                          slow = 1'b0;
  logic                          scan_chk = 1'b0;
  logic [7:0]                    rd_v;
  logic [7:0]                    d;
  int                            fails = 0;
  int                            total_checks = 0;
  int                            seed = 96027;
  int                            cnt;
  int                            bst;
  int                            f_tab [5] = '{3, 1, 1, 15, 2};
  int                            n_tab [5] = '{2, 1, 3, 1, 2};
  logic                          w_tab [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

  always #50 clk_sys_in = ~clk_sys_in;

  kdi_core #(.TICK_CYCLES(4)) dut_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .setup_addr_in(setup_addr_in), .setup_wr_in(setup_wr_in),
    .setup_wdata_in(setup_wdata_in), .setup_rdata_out(setup_rdata_out), .acq_req_out(acq_req_out),
    .acq_key_out(acq_key_out), .fast_burst_out(fast_burst_out), .acq_valid_in(acq_valid_in),
    .acq_touch_in(acq_touch_in), .acq_delta_in(acq_delta_in), .calibrating_in(calibrating_in),
    .sleep_en_in(sleep_en_in), .awake_time_in(awake_time_in), .change_ack_in(change_ack_in),
    .key_detect_out(key_detect_out), .awake_out(awake_out), .change_pin_in(1'b1),
    .change_pin_o_out(change_pin_o_out), .change_pin_oe_out(change_pin_oe_out));

  kdi_frontend_model fe_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .acq_req_in(acq_req_out), .acq_key_in(acq_key_out),
    .touch_in(touch), .deep_in(deep), .slow_in(slow), .acq_valid_out(acq_valid_in),
    .acq_touch_out(acq_touch_in), .acq_delta_out(acq_delta_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t %s seen %0h exp %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic int exp_conf(input int f, input int n);
    return ((f < 2) ? f : 2 * f) * (1 << n);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    setup_addr_in <= a;
    setup_wr_in <= 1'b1;
    setup_wdata_in <= v;
    @(posedge clk_sys_in);
    setup_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    setup_addr_in <= a;
    @(posedge clk_sys_in);
    #1;
    rd_v = setup_rdata_out;
  endtask

  task automatic ack();
    @(posedge clk_sys_in);
    change_ack_in <= 1'b1;
    @(posedge clk_sys_in);
    change_ack_in <= 1'b0;
  endtask

  // counts touched results of key k until its detect reaches v
  task automatic count_det(input int k, input logic v);
    cnt = 0;
    bst = 0;
    for (int i = 0; i < 5000; i++) begin
      @(posedge clk_sys_in);
      #1;
      if (key_detect_out[k] === v) return;
      if (acq_valid_in === 1'b1 && acq_key_out == k && acq_touch_in === 1'b1) cnt++;
      if (fast_burst_out === 1'b1) bst++;
    end
    check(1'b0, 1'b1, "detect wait timeout");
    report_and_stop();
  endtask

  task automatic wait_awake(input logic v);
    for (cnt = 0; cnt < 3000; cnt++) begin
      @(posedge clk_sys_in);
      #1;
      if (awake_out === v) return;
    end
    check(1'b0, 1'b1, "awake wait timeout");
    report_and_stop();
  endtask

  always @(posedge clk_sys_in) begin
    if (scan_chk && acq_req_out === 1'b1) check(en_mask[acq_key_out], 1'b1, "disabled key scanned");
  end

  initial begin
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (int k = 0; k < 24; k++) begin
      rd(kdi_pkg::SETUP_BASE + 8'(k));
      check(rd_v, {1'b1, 1'b0, 4'h3, 2'h2}, "setup default");
    end
    rd(8'hA4);
    check(rd_v, 8'h00, "unmapped low");
    rd(8'hBD);
    check(rd_v, 8'h00, "unmapped high");
    d = 8'($random(seed));
    wr(8'hBC, d);
    rd(8'hBC);
    check(rd_v, d, "readback");
    for (int k = 2; k < 24; k++) wr(kdi_pkg::SETUP_BASE + 8'(k), 8'h80);
    en_mask = 24'h00_0003;
    // let a request already scheduled for a dropped key drain first
    repeat (40) @(posedge clk_sys_in);
    scan_chk = 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(kdi_pkg::SETUP_BASE, {w_tab[i], 1'b0, 4'(f_tab[i]), 2'(n_tab[i])});
      touch <= 24'h00_0001;
      slow <= 1'($random(seed));
      count_det(0, 1'b1);
      check(cnt, exp_conf(f_tab[i], n_tab[i]), "confirmations");
      check(bst > 0, f_tab[i] > 1, "fast burst use");
      check(change_pin_oe_out, w_tab[i], "change on touch");
      ack();
      touch <= 24'h00_0000;
      count_det(0, 1'b0);
      check(change_pin_oe_out, w_tab[i], "change on release");
      ack();
    end
    wr(kdi_pkg::SETUP_BASE, 8'hCE);
    wr(kdi_pkg::SETUP_BASE + 8'h01, 8'hCE);
    deep <= 24'h00_0002;
    touch <= 24'h00_0003;
    count_det(1, 1'b1);
    check(key_detect_out[0], 1'b0, "weaker key suppressed");
    @(posedge clk_sys_in);
    deep <= 24'h00_0001;
    count_det(0, 1'b1);
    check(key_detect_out[1], 1'b1, "detect held");
    @(posedge clk_sys_in);
    touch <= 24'h00_0000;
    count_det(0, 1'b0);
    count_det(1, 1'b0);
    ack();
    calibrating_in <= 1'b1;
    sleep_en_in <= 1'b1;
    repeat (50) @(posedge clk_sys_in);
    #1;
    check(awake_out, 1'b1, "awake while calibrating");
    @(posedge clk_sys_in);
    calibrating_in <= 1'b0;
    wait_awake(1'b0);
    // tick restarts at zero while calibrating, so the first tick runs whole
    check(cnt >= 5, 1'b1, "awake period");
    @(posedge clk_sys_in);
    touch <= 24'h00_0001;
    wait_awake(1'b1);
    check(awake_out, 1'b1, "woken by touch");
    count_det(0, 1'b1);
    scan_chk = 1'b0;
    wr(kdi_pkg::SETUP_BASE, 8'h80);
    repeat (2) @(posedge clk_sys_in);
    #1;
    check(key_detect_out[0], 1'b0, "cleared on disable");
    report_and_stop();
  end
endmodule
